// *** src/sap_defines.vh ***
// Register map, field layout and timing constants of the port slice
`ifndef SAP_DEFINES_VH
`define SAP_DEFINES_VH
`define SAP_ADR_OUT8        8'h25
`define SAP_ADR_RXCFG       8'h26
`define SAP_ADR_FMT         8'h30
`define SAP_RST_OUT8        8'h07
`define SAP_RST_RXCFG       8'h00
`define SAP_RST_FMT         8'h00
`define SAP_OUT8_MASK       8'h3F
`define SAP_FMT_MASK        8'h07
`define SAP_BIT_SRC         5
`define SAP_BIT_EDGE        7
`define SAP_BIT_INTFS       6
`define SAP_BIT_INTBC       5
`define SAP_BIT_TDM         0
`define SAP_BIT_POL         1
`define SAP_BIT_CTRL        2
`define SAP_HALF_BIT        5'h10
`define SAP_WORD_BITS       6'h20
`define SAP_TDM_SLOTS       5'h1F
`define SAP_STAT_DEPTH      4'h8
`endif

// *** src/sap_shift_reg.v ***
// Capture register holding the last received word per data pin
`timescale 1ns/1ps
`include "sap_defines.vh"
module sap_shift_reg (
  ref_clk,
  rstn,
  shiftEn,
  bitIn,
  clearEn,
  wordOut
);
  input             ref_clk;
  input             rstn;
  input             shiftEn;
  input             bitIn;
  input             clearEn;
  output     [31:0] wordOut;
  reg        [31:0] word_ff;
  always @(posedge ref_clk) begin
    if (!rstn || clearEn) begin
      word_ff <= 32'h0000_0000;
    end else if (shiftEn) begin
      word_ff <= {word_ff[30:0], bitIn};
    end
  end
  assign wordOut = word_ff;
endmodule // sap_shift_reg

// *** src/sap_slot_config.v ***
// Secondary audio serial port: channel 8 output and receive timing
// Notes on behaviour
// R1 - Source bit zero: data line released during channel 8 slot.
// R2 - Source bit one: inter-chip link data driven in channel 8 slot.
// R3 - Slot values 0..15 select TDM slot n or left half slot n.
// R4 - Slot values 16..31 select TDM slot n or right half slot n-16.
// R5 - Reset: slot field 7, source bit zero, channel tri-stated.
// R6 - Software writes zero to the two upper reserved bits.
// R7 - Edge bit one latches input half a bit clock after default edge.
// R8 - Chosen edge applies to both serial data input pins.
// R9 - Controller mode: bit six picks internal or external frame sync.
// R10 - Controller mode: bit five picks internal or external bit clock.
// R11 - Offset field delays slot 0 MSB by n bit clocks.
// R12 - Zero offset means standard position; receive bits reset zero.
// R13 - Reserved bits ignore writes and read as zero.
`timescale 1ns/1ps
`include "sap_defines.vh"
module sap_slot_config (
  ref_clk,
  rstn,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  extBitClock,
  extFrameSync,
  intBitClock,
  intFrameSync,
  dataIn,
  dataIn2,
  interChipLinkData,
  dataOut,
  dataOutEn,
  rxWord,
  rxWord2,
  rxWordValid
);
  input             ref_clk;
  input             rstn;
  input             wb_cyc_i;
  input             wb_stb_i;
  input             wb_we_i;
  input      [7:0]  wb_adr_i;
  input      [3:0]  wb_sel_i;
  input      [31:0] wb_dat_i;
  output     [31:0] wb_dat_o;
  output            wb_ack_o;
  input             extBitClock;
  input             extFrameSync;
  input             intBitClock;
  input             intFrameSync;
  input             dataIn;
  input             dataIn2;
  input             interChipLinkData;
  output            dataOut;
  output            dataOutEn;
  output     [31:0] rxWord;
  output     [31:0] rxWord2;
  output            rxWordValid;

  // Registers
  reg        [7:0]  outCh8Cfg_ff;
  reg        [7:0]  rxCfg_ff;
  reg        [7:0]  fmtCfg_ff;
  reg        [31:0] wbDat_ff;
  reg               wbAck_ff;

  wire              wbReq = wb_cyc_i && wb_stb_i && !wbAck_ff;
  // Write lands at the edge where the master sees ack
  wire              wbWr  = wb_cyc_i && wb_stb_i && wbAck_ff &&
                            wb_we_i && wb_sel_i[0];

  always @(posedge ref_clk) begin
    if (!rstn) begin
      outCh8Cfg_ff <= `SAP_RST_OUT8; // see R5
      rxCfg_ff     <= `SAP_RST_RXCFG; // see R12
      fmtCfg_ff    <= `SAP_RST_FMT;
    end else if (wbWr) begin
      case (wb_adr_i)
        `SAP_ADR_OUT8: begin
          outCh8Cfg_ff <= wb_dat_i[7:0] & `SAP_OUT8_MASK; // see R13 R6
        end
        `SAP_ADR_RXCFG: begin
          rxCfg_ff <= wb_dat_i[7:0];
        end
        `SAP_ADR_FMT: begin
          fmtCfg_ff <= wb_dat_i[7:0] & `SAP_FMT_MASK; // see R13
        end
        default: begin
          fmtCfg_ff <= fmtCfg_ff;
        end
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (!rstn) begin
      wbAck_ff <= 1'b0;
      wbDat_ff <= 32'h0000_0000;
    end else begin
      wbAck_ff <= wbReq;
      if (wbReq) begin
        case (wb_adr_i)
          `SAP_ADR_OUT8:  wbDat_ff <= {24'h00_0000, outCh8Cfg_ff};
          `SAP_ADR_RXCFG: wbDat_ff <= {24'h00_0000, rxCfg_ff};
          `SAP_ADR_FMT:   wbDat_ff <= {24'h00_0000, fmtCfg_ff};
          default:        wbDat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_dat_o = wbDat_ff;
  assign wb_ack_o = wbAck_ff;

  // Field views
  wire              srcSel    = outCh8Cfg_ff[`SAP_BIT_SRC];
  wire       [4:0]  slotNum   = outCh8Cfg_ff[4:0];
  wire              rxEdge    = rxCfg_ff[`SAP_BIT_EDGE];
  wire              useIntFs  = rxCfg_ff[`SAP_BIT_INTFS];
  wire              useIntBc  = rxCfg_ff[`SAP_BIT_INTBC];
  wire       [4:0]  rxOffset  = rxCfg_ff[4:0];
  wire              tdmMode   = fmtCfg_ff[`SAP_BIT_TDM];
  wire              bcPol     = fmtCfg_ff[`SAP_BIT_POL];
  wire              ctrlMode  = fmtCfg_ff[`SAP_BIT_CTRL];

  // Pin synchronisers
  reg        [6:0]  sync1_ff;
  reg        [6:0]  sync2_ff;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      sync1_ff <= 7'h00;
      sync2_ff <= 7'h00;
    end else begin
      sync1_ff <= {extBitClock, extFrameSync, intBitClock, intFrameSync,
                   dataIn, dataIn2, interChipLinkData};
      sync2_ff <= sync1_ff;
    end
  end
  wire              sExtBc = sync2_ff[6];
  wire              sExtFs = sync2_ff[5];
  wire              sIntBc = sync2_ff[4];
  wire              sIntFs = sync2_ff[3];
  wire              sDin   = sync2_ff[2];
  wire              sDin2  = sync2_ff[1];
  wire              sLink  = sync2_ff[0];

  // Clock and frame-sync selection
  wire selBc = (ctrlMode && useIntBc) ? sIntBc : sExtBc; // see R10
  wire selFs = (ctrlMode && useIntFs) ? sIntFs : sExtFs; // see R9

  reg               bc_ff;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      bc_ff <= 1'b0;
    end else begin
      bc_ff <= selBc;
    end
  end
  wire bcRise = selBc && !bc_ff;
  wire bcFall = !selBc && bc_ff;

  // Default latch edge follows polarity; transmit on the other edge
  wire defLatch = bcPol ? bcFall : bcRise;
  wire defLaunch = bcPol ? bcRise : bcFall;
  wire rxLatch = rxEdge ? defLaunch : defLatch; // see R7

  // Frame sync judged at latch edges only, so it lines up with data
  reg               fsLvl_ff;
  reg        [9:0]  bitCnt_ff;
  reg               half_ff;
  wire              fsEdge  = tdmMode ? (selFs && !fsLvl_ff)
                                      : (selFs != fsLvl_ff);
  wire              frameGo = defLatch && fsEdge;
  wire       [9:0]  nxt_bitCnt = frameGo ? 10'h000 : bitCnt_ff + 10'h001;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      fsLvl_ff  <= 1'b0;
      bitCnt_ff <= 10'h000;
      half_ff   <= 1'b0;
    end else if (defLatch) begin
      fsLvl_ff  <= selFs;
      bitCnt_ff <= nxt_bitCnt;
      if (frameGo) begin
        half_ff <= tdmMode ? 1'b0 : !selFs;
      end
    end
  end

  // Slot decoding, shared by both halves
  function [9:0] slotStart;
    input [4:0] n;
    begin
      slotStart = {n, 5'h00};
    end
  endfunction

  // Index inside the word at base; difference avoids end overflow
  function inWord;
    input [9:0] idx;
    input [9:0] base;
    begin
      inWord = (idx >= base) &&
               ((idx - base) < {4'h0, `SAP_WORD_BITS});
    end
  endfunction

  // Channel 8 transmit slot
  wire       [4:0]  tdmSlot  = slotNum;
  wire              wantRight = slotNum[4]; // see R4
  wire       [4:0]  halfSlot = {1'b0, slotNum[3:0]}; // see R3
  wire       [9:0]  txBase   = tdmMode ? slotStart(tdmSlot)
                                       : slotStart(halfSlot);
  wire              txHalfOk = tdmMode || (half_ff == wantRight);
  // Launch edge prepares the bit after the one last latched
  wire       [9:0]  txNext   = bitCnt_ff + 10'h001;
  wire              inTxSlot = txHalfOk && inWord(txNext, txBase);

  reg               dout_ff;
  reg               doutEn_ff;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      dout_ff   <= 1'b0;
      doutEn_ff <= 1'b0;
    end else if (!srcSel) begin
      doutEn_ff <= 1'b0; // see R1
      dout_ff   <= 1'b0;
    end else if (defLaunch) begin
      doutEn_ff <= inTxSlot; // see R2
      dout_ff   <= inTxSlot ? sLink : 1'b0; // see R2
    end
  end
  assign dataOut   = dout_ff;
  assign dataOutEn = doutEn_ff;

  // Receive slot 0 with offset, on both input pins
  wire       [9:0]  rxStart = {5'h00, rxOffset}; // see R11 R12
  // Delayed edge latches the bit whose default edge just passed
  wire       [9:0]  rxIdx   = rxEdge ? bitCnt_ff : nxt_bitCnt;
  wire              rxShift = rxLatch && inWord(rxIdx, rxStart);
  wire       [9:0]  rxEnd   = rxStart + {4'h0, `SAP_WORD_BITS} - 10'h001;
  reg               rxLast_ff;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      rxLast_ff <= 1'b0;
    end else begin
      rxLast_ff <= rxShift && (rxIdx == rxEnd);
    end
  end

  sap_shift_reg uRx1 (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .shiftEn (rxShift), // see R8
    .bitIn   (sDin),
    .clearEn (1'b0),
    .wordOut (rxWord)
  );
  sap_shift_reg uRx2 (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .shiftEn (rxShift), // see R8
    .bitIn   (sDin2),
    .clearEn (1'b0),
    .wordOut (rxWord2)
  );
  assign rxWordValid = rxLast_ff;
endmodule // sap_slot_config

// *** tb/sap_slot_config_props.sv ***
// Checker of bus answers, read masks and channel 8 drive
`timescale 1ns/1ps
`include "sap_defines.vh"
module sap_slot_config_chk (
  input logic        ref_clk,
  input logic        rstn,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [7:0]  wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  input logic        dataOutEn
);
  logic srcFf;
  wire  rd = wb_ack_o && !wb_we_i;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Shadow of the channel 8 source bit
  always_ff @(posedge ref_clk)
    if (!rstn) srcFf <= 1'b0;
    else if (wb_ack_o && wb_we_i && wb_adr_i == `SAP_ADR_OUT8)
      srcFf <= wb_dat_i[`SAP_BIT_SRC];
  a_reset_quiet: assert property (disable iff (1'b0)
    !rstn |=> !wb_ack_o && !dataOutEn) else $error("busy after reset");
  a_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ack_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  a_tri_src0: assert property ((!srcFf) [*3] |-> !dataOutEn)
    else $error("driven with source zero");
  a_out8_mask: assert property (
    rd && wb_adr_i == `SAP_ADR_OUT8 |-> wb_dat_o[31:6] == 26'h0)
    else $error("out8 reserved bits set");
  a_rx_width: assert property (
    rd && wb_adr_i == `SAP_ADR_RXCFG |-> wb_dat_o[31:8] == 24'h0)
    else $error("receive upper bits set");
  a_unmapped_zero: assert property (
    rd && wb_adr_i == 8'h27 |-> wb_dat_o == 32'h0) else $error("unmapped");
endmodule // sap_slot_config_chk
bind sap_slot_config sap_slot_config_chk chk (.ref_clk(ref_clk),
  .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dataOutEn(dataOutEn));

// *** tb/sap_link_model.sv ***
// Far-end port model: bit clock, frame sync, data, slot capture
`timescale 1ns/1ps
module sap_link_model (
  output logic bitClk,
  output logic frame_sync,
  output logic dIn,
  output logic dIn2,
  input  logic dOut,
  input  logic dOutEn,
  output int   enFirst,
  output int   enCount
);
  initial {bitClk, frame_sync, dIn, dIn2} = 4'h0;
  // n bits per frame; lr gives a half-frame sync, late moves data
  // changes past the rising edge
  task automatic frame(input logic [31:0] w0, w1, input int off, late, lr,
                       n);
    logic [1:0] b;
    enFirst = -1;
    enCount = 0;
    #13;
    for (int i = 0; i < n; i++) begin
      b = (i >= off && i < off + 32) ? {w0[31 + off - i], w1[31 + off - i]}
        : {2{i < off}};
      bitClk = 0;
      #80 frame_sync = lr ? (i < n / 2) : (i == 0);
      if (!late) {dIn, dIn2} = b;
      #80 bitClk = 1;
      #80 if (late) {dIn, dIn2} = b;
      #80 if (dOutEn === 1'b1 && enFirst < 0) enFirst = i;
      enCount += (dOutEn === 1'b1 && dOut === 1'b1);
    end
    bitClk = 0;
    {dIn, dIn2} = ~{dIn, dIn2};
  endtask
endmodule // sap_link_model

// *** tb/test_sap_slot_config.sv ***
// Self-checking bench of the channel 8 and receive timing slice
`timescale 1ns/1ps
`include "sap_defines.vh"
module test_sap_slot_config;
  logic        refClk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, useInt = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] datI = 32'h0000_0000, datO, rxW, rxW2, q;
  logic        ack, dOut, dOutEn, bitClk, frame_sync, dIn, dIn2, rxV;
  logic        linkBit = 1;
  int          enFirst, enCount, vCount = 0, failures = 0, cmp_count = 0;
  // Rows: format, channel 8 config, link bit, first driven bit, ones
  logic [7:0]  rowFmt [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
  logic [7:0]  rowCfg [6] = '{8'h07, 8'h2F, 8'h30, 8'h3F, 8'h2F, 8'h31};
  logic        rowLink [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  int          rowFirst [6] = '{-1, 480, 512, 992, 480, 544};
  int          rowBits [6] = '{0, 32, 32, 32, 32, 0};
  always #20 refClk = ~refClk;
  always @(posedge refClk) if (rxV === 1'b1) vCount <= vCount + 1;
  sap_slot_config dut (.ref_clk(refClk), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .extBitClock(bitClk & !useInt), .extFrameSync(frame_sync & !useInt),
    .intBitClock(bitClk & useInt), .intFrameSync(frame_sync & useInt),
    .dataIn(dIn), .dataIn2(dIn2), .interChipLinkData(linkBit),
    .dataOut(dOut), .dataOutEn(dOutEn), .rxWord(rxW), .rxWord2(rxW2),
    .rxWordValid(rxV));
  sap_link_model link (.bitClk(bitClk), .frame_sync(frame_sync), .dIn(dIn),
    .dIn2(dIn2), .dOut(dOut), .dOutEn(dOutEn), .enFirst(enFirst),
    .enCount(enCount));
  task automatic chk(input string n, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wbx(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge refClk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= {24'h00_0000, d};
    @(posedge refClk iff ack === 1'b1);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rxTest(input logic [7:0] cfg, input int off, late);
    int v0;
    wbx(`SAP_ADR_RXCFG, 1'b1, cfg);
    v0 = vCount;
    link.frame(32'hA5C3_0F96, 32'h3C5A_F00F, off, late, 0, 128);
    chk("rxWord", rxW, 32'hA5C3_0F96);
    chk("rxWord2", rxW2, 32'h3C5A_F00F);
    chk("rxValid", vCount - v0, 1);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #3_000_000;
    failures++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge refClk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wbx(`SAP_ADR_FMT, 1'b1, rowFmt[i]);
      linkBit <= rowLink[i];
      wbx(`SAP_ADR_OUT8, 1'b1, rowCfg[i]);
      wbx(`SAP_ADR_OUT8, 1'b0, 8'h00);
      chk("out8", q, {24'h00_0000, rowCfg[i]});
      link.frame(0, 0, 0, 0, !rowFmt[i][0], 1024);
      chk("slotStart", enFirst, rowFirst[i]);
      chk("linkBits", enCount, rowBits[i]);
    end
    @(posedge refClk);
    rstn <= 1'b0;
    repeat (3) @(posedge refClk);
    rstn <= 1'b1;
    wbx(`SAP_ADR_OUT8, 1'b0, 8'h00);
    chk("out8Reset", q, 32'h0000_0007);
    wbx(`SAP_ADR_RXCFG, 1'b0, 8'h00);
    chk("rxReset", q, 32'h0000_0000);
    wbx(8'h27, 1'b0, 8'h00);
    chk("unmapped", q, 32'h0000_0000);
    wbx(`SAP_ADR_FMT, 1'b1, 8'h01);
    rxTest(8'h00, 0, 0);
    wbx(`SAP_ADR_FMT, 1'b1, 8'h03);
    rxTest(8'h02, 2, 0);
    wbx(`SAP_ADR_FMT, 1'b1, 8'h01);
    rxTest(8'h85, 5, 1);
    wbx(`SAP_ADR_FMT, 1'b1, 8'h05);
    useInt <= 1'b1;
    rxTest(8'h60, 0, 0);
    summarize();
  end
endmodule // test_sap_slot_config
